// ==== hdl/pwr_mode_wake_seq.sv ====
// power mode, wake and clock gating sequencer with a wishbone slave
// ===================================================
// Summary of operation
// [R1] usb clock synth disabled and unpowered after reset until software enables
// [R2] usb block clocked from main synth 48 MHz while usb synth disabled
// [R3] usb synth fed only by main oscillator, output only to usb block
// [R4] clock output pin selects cpu, rc, crystal, rtc or usb clock
// [R5] run from internal rc oscillator at power-up and power-down wake
// [R6] software enables and waits for a source before selecting it
// [R7] every power-down wake passes through the wake-up timer
// [R8] sleep stops only core clock; peripheral clocks keep running
// [R9] sleep ends on reset or interrupt by re-enabling core clock only
// [R10] deep-sleep stops clocks, gates rc output, keeps rc powered, keeps state
// [R11] deep-sleep entry disables main synth and zeroes cpu and usb dividers
// [R12] deep-sleep left on reset or clockless interrupt; flash stays powered
// [R13] deep-sleep wake resumes after 4 rc or 4096 main oscillator cycles
// [R14] power-down adds removal of rc oscillator and flash power
// [R15] power-down wake: 60 us rc start-up then 4 cycles before resuming
// [R16] flash wake counter blocks flash access for 100 us after wake
// [R17] software reprograms synth and dividers after any deep wake
// [R18] deep power-down only on rtc request; all but rtc and reset off
// [R19] deep power-down left only by reset pin or rtc alarm
// [R20] irq unit hands wake monitor its enabled, urgent mask on entry
// [R21] wake monitor wakes cpu when any masked irq line asserts
// [R22] each peripheral has its own software clock gate and divider
// [R23] main synth off and bypassed after reset and power-down entry
// [R24] one mode at a time; reduced modes entered only from run
`timescale 1ns/10ps
module pwr_mode_wake_seq
	import pwr_seq_pkg::*;
#(
	parameter int NIRQ = 32,
	parameter int NPER = 16,
	parameter int IRC_START_CNT = IRC_START_CYC,
	parameter int FLASH_WAKE_CNT = FLASH_WAKE_CYC
) (
	input wire logic ref_clk_i, // 100 MHz clock
	input wire logic sys_rst_i, // chip reset, sync high
	input wire logic clk_en_i, // freezes all state when low, except that an rtc alarm in deep power-down still resets the registers
	input wire wb_req_t wb_req_i, // wishbone request
	output logic [31:0] wb_dat_o, // wishbone read data
	output logic wb_ack_o, // wishbone ack
	input wire logic sleep_req_i, // core waits for interrupt
	input wire logic rtc_dpd_req_i, // rtc deep power-down request
	input wire logic rtc_alarm_i, // rtc alarm match
	input wire logic [NIRQ-1:0] irq_i, // interrupt lines
	input wire logic [NIRQ-1:0] irq_mask_i, // irq unit wake mask
	output logic core_clk_en_o, // core clock gate
	output logic [NPER-1:0] pclk_en_o, // peripheral clock enables
	output logic irc_out_en_o, // rc oscillator output gate
	output logic irc_pwr_o, // rc oscillator power
	output logic flash_pwr_o, // flash power
	output logic flash_ready_o, // flash access allowed
	output logic chip_pwr_o, // main domain power
	output logic main_synth_en_o, // main synth enable
	output logic main_synth_conn_o, // main synth connected
	output logic usb_synth_pwr_o, // usb synth enable and power
	output logic usb_clk_sel_o, // 1 usb synth, 0 main synth
	output logic [1:0] cpu_src_o, // cpu clock source
	output logic [7:0] cpu_div_o, // cpu clock divider
	output logic [3:0] usb_div_o, // usb clock divider
	output logic [2:0] clkout_sel_o, // clock output select
	output logic wake_evt_o // pulse on resume to run from ST_WAKE_CNT
);
	// ===================================================
	// helpers
	function automatic logic [31:0] merge(
		input logic [31:0] old,
		input logic [31:0] din,
		input logic [3:0] sel
	);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) begin
				r[b*8 +: 8] = din[b*8 +: 8];
			end
		end
		return r;
	endfunction : merge

	function automatic logic [2:0] div_mask(input logic [1:0] code);
		unique case (code)
			2'h0: div_mask = 3'h0;
			2'h1: div_mask = 3'h1;
			2'h2: div_mask = 3'h3;
			2'h3: div_mask = 3'h7;
		endcase
	endfunction : div_mask

	// ===================================================
	// declarations
	pwr_state_t state_ff, nxt_state;
	logic [31:0] ctrl_ff, clkdiv_ff, clkout_ff, pgate_ff, pdiv_ff;
	logic [NIRQ-1:0] wmask_ff;
	logic [31:0] rdata;
	logic ack_ff;
	logic [31:0] rd_ff;
	logic wr;
	logic entering, deep_entry, pd_entry, dpd_wake;
	logic wake_hit;
	logic tmr_ld_ff, fl_ld_ff;
	logic [15:0] tmr_cnt_ff;
	logic tmr_busy, fl_busy;
	logic [2:0] pdiv_cnt_ff;
	logic core_clk_ff, periph_run, irc_out_ff, irc_pwr_ff;
	logic flash_pwr_ff, flash_rdy_ff, chip_pwr_ff, wake_evt_ff;
	logic [NPER-1:0] pclk_ff;

	// ===================================================
	// wishbone slave: ack one cycle after the request; write lands with ack
	assign wr = wb_req_i.cyc & wb_req_i.stb & wb_req_i.we & ack_ff;

	always_comb begin
		rdata = 32'h0000_0000;
		unique case (wb_req_i.adr)
			OFS_CTRL: rdata = ctrl_ff;
			OFS_CLKDIV: rdata = clkdiv_ff;
			OFS_CLKOUT: rdata = clkout_ff;
			OFS_PGATE: rdata = pgate_ff;
			OFS_PDIV: rdata = pdiv_ff;
			OFS_STATUS: rdata = {25'h0, core_clk_ff, flash_rdy_ff,
				tmr_busy, 1'b0, state_ff};
			OFS_WMASK: rdata = 32'(wmask_ff);
			default: rdata = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			ack_ff <= 1'b0;
			rd_ff <= 32'h0000_0000;
		end else if (clk_en_i) begin
			ack_ff <= wb_req_i.cyc & wb_req_i.stb & ~ack_ff;
			rd_ff <= rdata;
		end
	end

	// ===================================================
	// sequencer state
	assign wake_hit = |(irq_i & wmask_ff); // [R21]
	assign entering = (state_ff == ST_RUN) && (nxt_state != ST_RUN);
	assign deep_entry = entering && (nxt_state != ST_SLEEP);
	assign pd_entry = entering && (nxt_state inside {ST_PDOWN, ST_DPD});
	assign dpd_wake = (state_ff == ST_DPD) && rtc_alarm_i;
	assign periph_run = nxt_state inside {ST_RUN, ST_SLEEP,
		ST_WAKE_CNT}; // [R8] [R10]

	always_comb begin
		nxt_state = state_ff;
		unique case (state_ff)
			ST_RUN: begin
				if (rtc_dpd_req_i) begin
					nxt_state = ST_DPD; // [R18]
				end else if (sleep_req_i) begin
					unique case (ctrl_ff[CTRL_MODE_LSB +: 2]) // [R24]
						MODE_SLEEP: nxt_state = ST_SLEEP;
						MODE_DSLEEP: nxt_state = ST_DSLEEP;
						MODE_PDOWN: nxt_state = ST_PDOWN;
						default: nxt_state = ST_RUN;
					endcase
				end
			end
			ST_SLEEP: begin
				if (|(irq_i & irq_mask_i)) begin
					nxt_state = ST_RUN; // [R9]
				end
			end
			ST_DSLEEP: begin
				if (wake_hit) begin
					nxt_state = ST_WAKE_CNT; // [R12]
				end
			end
			ST_PDOWN: begin
				if (wake_hit) begin
					nxt_state = ST_IRC_START; // [R7]
				end
			end
			ST_DPD: begin
				if (rtc_alarm_i) begin
					nxt_state = ST_IRC_START; // [R19]
				end
			end
			ST_IRC_START: begin
				if (!tmr_ld_ff && !tmr_busy) begin
					nxt_state = ST_WAKE_CNT; // [R15]
				end
			end
			ST_WAKE_CNT: begin
				if (!tmr_ld_ff && !tmr_busy) begin
					nxt_state = ST_RUN; // [R13]
				end
			end
			default: nxt_state = ST_RUN;
		endcase
	end

	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			state_ff <= ST_RUN;
		end else if (clk_en_i) begin
			state_ff <= nxt_state;
		end
	end

	// mask taken from the irq unit only as a deep mode is entered
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			wmask_ff <= '0;
		end else if (clk_en_i && deep_entry) begin
			wmask_ff <= irq_mask_i; // [R20]
		end
	end

	// ===================================================
	// wake and flash delay timers
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			tmr_ld_ff <= 1'b0;
			tmr_cnt_ff <= 16'h0000;
			fl_ld_ff <= 1'b0;
		end else if (clk_en_i) begin
			tmr_ld_ff <= 1'b0;
			fl_ld_ff <= 1'b0;
			if (state_ff == ST_DSLEEP && wake_hit) begin
				tmr_ld_ff <= 1'b1;
				tmr_cnt_ff <= (ctrl_ff[CTRL_SRC_LSB +: 2] == SRC_MAIN)
					? WAKE_MAIN_CYC : WAKE_IRC_CYC; // [R13]
			end else if (nxt_state == ST_IRC_START &&
				state_ff != ST_IRC_START) begin
				tmr_ld_ff <= 1'b1;
				tmr_cnt_ff <= 16'(IRC_START_CNT); // [R15]
			end else if (state_ff == ST_IRC_START &&
				nxt_state == ST_WAKE_CNT) begin
				tmr_ld_ff <= 1'b1;
				tmr_cnt_ff <= WAKE_SRAM_CYC; // [R15]
				fl_ld_ff <= 1'b1; // [R16]
			end
		end
	end

	wake_timer #(.W(16)) u_wake_tmr (
		.ref_clk_i(ref_clk_i),
		.sys_rst_i(sys_rst_i),
		.clk_en_i(clk_en_i),
		.load_i(tmr_ld_ff),
		.count_i(tmr_cnt_ff),
		.busy_o(tmr_busy)
	);

	wake_timer #(.W(16)) u_flash_tmr (
		.ref_clk_i(ref_clk_i),
		.sys_rst_i(sys_rst_i),
		.clk_en_i(clk_en_i),
		.load_i(fl_ld_ff),
		.count_i(16'(FLASH_WAKE_CNT)),
		.busy_o(fl_busy)
	);

	// ===================================================
	// software registers with hardware overrides on deep entry
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i || dpd_wake) begin
			ctrl_ff <= RST_CTRL; // [R1] [R23]
			clkdiv_ff <= RST_CLKDIV;
			clkout_ff <= RST_CLKOUT;
			pgate_ff <= RST_PGATE;
			pdiv_ff <= RST_PDIV;
		end else if (clk_en_i) begin
			if (wr) begin
				unique case (wb_req_i.adr)
					OFS_CTRL: ctrl_ff <= merge(ctrl_ff,
						wb_req_i.dat, wb_req_i.sel);
					OFS_CLKDIV: clkdiv_ff <= merge(clkdiv_ff,
						wb_req_i.dat, wb_req_i.sel);
					OFS_CLKOUT: clkout_ff <= merge(clkout_ff,
						wb_req_i.dat, wb_req_i.sel); // [R4]
					OFS_PGATE: pgate_ff <= merge(pgate_ff,
						wb_req_i.dat, wb_req_i.sel); // [R22]
					OFS_PDIV: pdiv_ff <= merge(pdiv_ff,
						wb_req_i.dat, wb_req_i.sel); // [R22]
					default: ;
				endcase
			end
			// entry overrides a same-cycle write: the core is stopping
			if (deep_entry) begin
				ctrl_ff[CTRL_MAIN_EN] <= 1'b0; // [R11]
				ctrl_ff[CTRL_MAIN_CONN] <= 1'b0; // [R11]
				clkdiv_ff <= 32'h0000_0000; // [R11]
			end
			if (pd_entry) begin
				ctrl_ff[CTRL_SRC_LSB +: 2] <= SRC_IRC; // [R5] [R23]
			end
		end
	end

	// ===================================================
	// clock and power controls follow the next state
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			core_clk_ff <= 1'b1;
			irc_out_ff <= 1'b1;
			irc_pwr_ff <= 1'b1;
			flash_pwr_ff <= 1'b1;
			chip_pwr_ff <= 1'b1;
		end else if (clk_en_i) begin
			core_clk_ff <= (nxt_state == ST_RUN); // [R8] [R9]
			irc_out_ff <= !(nxt_state inside {ST_DSLEEP, ST_PDOWN,
				ST_DPD}); // [R10]
			irc_pwr_ff <= !(nxt_state inside {ST_PDOWN,
				ST_DPD}); // [R14]
			flash_pwr_ff <= !(nxt_state inside {ST_PDOWN,
				ST_DPD}); // [R12] [R14]
			chip_pwr_ff <= (nxt_state != ST_DPD); // [R18]
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			flash_rdy_ff <= 1'b1;
			wake_evt_ff <= 1'b0;
		end else if (clk_en_i) begin
			flash_rdy_ff <= flash_pwr_ff && !fl_busy && !fl_ld_ff &&
				(state_ff != ST_IRC_START) &&
				!(nxt_state inside {ST_PDOWN, ST_DPD,
				ST_IRC_START}); // [R16]
			wake_evt_ff <= (state_ff == ST_WAKE_CNT) &&
				(nxt_state == ST_RUN);
		end
	end

	// ===================================================
	// per-peripheral gates and dividers on a shared prescaler
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			pdiv_cnt_ff <= 3'h0;
		end else if (clk_en_i) begin
			pdiv_cnt_ff <= pdiv_cnt_ff + 3'h1;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			pclk_ff <= '0;
		end else if (clk_en_i) begin
			for (int p = 0; p < NPER; p++) begin
				pclk_ff[p] <= pgate_ff[p] && periph_run &&
					((pdiv_cnt_ff & div_mask(pdiv_ff[2*p +: 2])) ==
					div_mask(pdiv_ff[2*p +: 2])); // [R22]
			end
		end
	end

	// ===================================================
	// outputs
	// the usb synth reference is hard-wired to the main oscillator;
	// this block only enables it and picks which 48 MHz feeds usb
	assign usb_synth_pwr_o = ctrl_ff[CTRL_USB_EN]; // [R1] [R3]
	assign usb_clk_sel_o = ctrl_ff[CTRL_USB_EN] &
		ctrl_ff[CTRL_USB_CONN]; // [R2]
	assign main_synth_en_o = ctrl_ff[CTRL_MAIN_EN]; // [R23]
	assign main_synth_conn_o = ctrl_ff[CTRL_MAIN_CONN]; // [R23]
	assign cpu_src_o = ctrl_ff[CTRL_SRC_LSB +: 2]; // [R5]
	assign cpu_div_o = clkdiv_ff[7:0];
	assign usb_div_o = clkdiv_ff[DIV_USB_LSB +: 4];
	assign clkout_sel_o = clkout_ff[2:0]; // [R4]
	assign core_clk_en_o = core_clk_ff;
	assign pclk_en_o = pclk_ff;
	assign irc_out_en_o = irc_out_ff;
	assign irc_pwr_o = irc_pwr_ff;
	assign flash_pwr_o = flash_pwr_ff;
	assign flash_ready_o = flash_rdy_ff;
	assign chip_pwr_o = chip_pwr_ff;
	assign wake_evt_o = wake_evt_ff;
	assign wb_ack_o = ack_ff;
	assign wb_dat_o = rd_ff;
endmodule : pwr_mode_wake_seq

// ==== hdl/wake_timer.sv ====
// down counter used for oscillator start-up and flash wake-up delays
`timescale 1ns/10ps
module wake_timer #(
	parameter int W = 16
) (
	input wire logic ref_clk_i, // clock
	input wire logic sys_rst_i, // sync reset
	input wire logic clk_en_i, // freezes the count
	input wire logic load_i, // start a new delay
	input wire logic [W-1:0] count_i, // delay in cycles
	output logic busy_o // high while counting
);
	logic [W-1:0] cnt_ff;

	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			cnt_ff <= '0;
		end else if (clk_en_i) begin
			if (load_i) begin
				cnt_ff <= count_i;
			end else if (cnt_ff != '0) begin
				cnt_ff <= cnt_ff - 1'b1;
			end
		end
	end

	assign busy_o = (cnt_ff != '0);
endmodule : wake_timer

// ==== inc/pwr_seq_pkg.sv ====
// constants and types shared by the power mode and wake sequencer
package pwr_seq_pkg;
	// ===================================================
	// timing
	localparam int CLK_MHZ = 100;
	localparam int IRC_START_US = 60;
	localparam int FLASH_WAKE_US = 100;
	localparam int IRC_START_CYC = IRC_START_US * CLK_MHZ;
	localparam int FLASH_WAKE_CYC = FLASH_WAKE_US * CLK_MHZ;
	localparam logic [15:0] WAKE_IRC_CYC = 16'h0004;
	localparam logic [15:0] WAKE_MAIN_CYC = 16'h1000;
	localparam logic [15:0] WAKE_SRAM_CYC = 16'h0004;

	// ===================================================
	// register offsets (byte addresses)
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_CLKDIV = 8'h04;
	localparam logic [7:0] OFS_CLKOUT = 8'h08;
	localparam logic [7:0] OFS_PGATE = 8'h0C;
	localparam logic [7:0] OFS_PDIV = 8'h10;
	localparam logic [7:0] OFS_STATUS = 8'h14;
	localparam logic [7:0] OFS_WMASK = 8'h18;

	// ===================================================
	// field positions and reset values
	localparam int CTRL_MODE_LSB = 0;
	localparam int CTRL_MAIN_EN = 2;
	localparam int CTRL_MAIN_CONN = 3;
	localparam int CTRL_USB_EN = 4;
	localparam int CTRL_USB_CONN = 5;
	localparam int CTRL_SRC_LSB = 6;
	localparam int DIV_USB_LSB = 8;
	localparam logic [31:0] RST_CTRL = 32'h0000_0000;
	localparam logic [31:0] RST_CLKDIV = 32'h0000_0000;
	localparam logic [31:0] RST_CLKOUT = 32'h0000_0000;
	localparam logic [31:0] RST_PGATE = 32'h0000_0000;
	localparam logic [31:0] RST_PDIV = 32'h0000_0000;

	// ===================================================
	// encodings
	localparam logic [1:0] MODE_SLEEP = 2'h0;
	localparam logic [1:0] MODE_DSLEEP = 2'h1;
	localparam logic [1:0] MODE_PDOWN = 2'h2;
	localparam logic [1:0] SRC_IRC = 2'h0;
	localparam logic [1:0] SRC_MAIN = 2'h1;
	localparam logic [1:0] SRC_RTC = 2'h2;
	localparam logic [2:0] CLKOUT_CPU = 3'h0;
	localparam logic [2:0] CLKOUT_IRC = 3'h1;
	localparam logic [2:0] CLKOUT_XTAL = 3'h2;
	localparam logic [2:0] CLKOUT_RTC = 3'h3;
	localparam logic [2:0] CLKOUT_USB = 3'h4;

	typedef enum logic [2:0] {
		ST_RUN,
		ST_SLEEP,
		ST_DSLEEP,
		ST_PDOWN,
		ST_DPD,
		ST_IRC_START,
		ST_WAKE_CNT
	} pwr_state_t;

	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [7:0] adr;
		logic [3:0] sel;
		logic [31:0] dat;
	} wb_req_t;
endpackage : pwr_seq_pkg

// ==== sim/core_irq_model.sv ====
// stand-in for the core and its irq unit: wait requests and irq lines
`timescale 1ns/10ps
module core_irq_model #(
	parameter int NIRQ = 32
) (
	input wire logic ref_clk_i, // clock
	output logic sleep_req_o, // wait for interrupt
	output logic [NIRQ-1:0] irq_o, // interrupt lines
	output logic [NIRQ-1:0] irq_mask_o // enabled urgent irqs
);
	// ===================================
	// behaviour
	// lines 4..7 enabled and urgent; others may pend but never wake
	initial begin
		sleep_req_o = 1'b0;
		irq_o = '0;
		irq_mask_o = {{(NIRQ - 8){1'b0}}, 8'hF0};
	end
	task automatic wfi();
		@(posedge ref_clk_i);
		sleep_req_o <= 1'b1;
		@(posedge ref_clk_i);
		sleep_req_o <= 1'b0;
	endtask : wfi
	// hold sets how slowly the line is withdrawn
	task automatic fire(input int idx, input int hold);
		@(posedge ref_clk_i);
		irq_o[idx] <= 1'b1;
		repeat (hold) @(posedge ref_clk_i);
		irq_o[idx] <= 1'b0;
	endtask : fire
endmodule : core_irq_model

// ==== sim/pwr_seq_chk.sv ====
// port assertions for the power mode and wake sequencer
`timescale 1ns/10ps
module pwr_seq_chk
	import pwr_seq_pkg::*;
#(
	parameter int NIRQ = 32,
	parameter int NPER = 16,
	parameter int IRC_START_CNT = 20
) (
	input wire logic ref_clk_i, // clock
	input wire logic sys_rst_i, // reset
	input wire logic rtc_dpd_req_i, // rtc request
	input wire logic rtc_alarm_i, // rtc alarm
	input wire logic [NIRQ-1:0] irq_i, // irq lines
	input wire logic [NIRQ-1:0] irq_mask_i, // wake mask
	input wire logic core_clk_en_o, // core gate
	input wire logic [NPER-1:0] pclk_en_o, // peripheral gates
	input wire logic irc_out_en_o, // rc gate
	input wire logic irc_pwr_o, // rc power
	input wire logic flash_pwr_o, // flash power
	input wire logic chip_pwr_o, // main power
	input wire logic main_synth_en_o, // main synth
	input wire logic main_synth_conn_o, // main synth link
	input wire logic usb_synth_pwr_o, // usb synth
	input wire logic usb_clk_sel_o, // usb clock pick
	input wire logic [1:0] cpu_src_o, // cpu source
	input wire logic [7:0] cpu_div_o, // cpu divider
	input wire logic [3:0] usb_div_o, // usb divider
	input wire logic wake_evt_o // wake pulse
);
	localparam int PD_LO = IRC_START_CNT;
	localparam int PD_HI = IRC_START_CNT + 20;
	logic [NIRQ-1:0] cap_ff;
	logic slp_ff;
	logic alm_ff;
	logic ds_hit;
	logic pd_hit;
	// ===================================
	// helpers
	// the mask freezes once the rc output is gated, as on deep entry
	always_ff @(posedge ref_clk_i) begin
		if (irc_out_en_o)
			cap_ff <= irq_mask_i;
	end
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i || core_clk_en_o)
			slp_ff <= 1'b0;
		else if ($fell(core_clk_en_o) && irc_out_en_o)
			slp_ff <= 1'b1;
	end
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i || chip_pwr_o)
			alm_ff <= 1'b0;
		else if (rtc_alarm_i)
			alm_ff <= 1'b1;
	end
	assign ds_hit = chip_pwr_o && irc_pwr_o && !irc_out_en_o &&
		|(irq_i & cap_ff);
	assign pd_hit = chip_pwr_o && !irc_pwr_o && |(irq_i & cap_ff);
	// ===================================
	// assertions
	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (sys_rst_i);
	AST_RST_OFF: assert property ($past(sys_rst_i) |->
		!usb_synth_pwr_o && !main_synth_en_o && cpu_src_o == SRC_IRC)
		else $error("synth or source wrong after reset");
	AST_USB_SEL: assert property (usb_clk_sel_o |-> usb_synth_pwr_o)
		else $error("usb clock taken from a disabled synth");
	AST_DS_ENTRY: assert property (
		$fell(irc_out_en_o) && irc_pwr_o |->
		!core_clk_en_o && pclk_en_o == '0 && !main_synth_en_o &&
		!main_synth_conn_o && cpu_div_o == 8'h00 && usb_div_o == 4'h0)
		else $error("deep sleep entry effects missing");
	AST_PD_ENTRY: assert property ($fell(irc_pwr_o) |->
		!flash_pwr_o && !main_synth_en_o && cpu_src_o == SRC_IRC)
		else $error("power down entry effects missing");
	AST_DPD_ENTRY: assert property ($fell(chip_pwr_o) |->
		$past(rtc_dpd_req_i))
		else $error("deep power down without rtc request");
	AST_DPD_EXIT: assert property ($rose(chip_pwr_o) |-> alm_ff)
		else $error("deep power down left without alarm");
	AST_DS_WAKE: assert property ($rose(ds_hit) &&
		cpu_src_o == SRC_IRC |-> ##[2:10] wake_evt_o)
		else $error("deep sleep wake late");
	AST_PD_WAKE: assert property ($rose(pd_hit) |->
		##[PD_LO:PD_HI] wake_evt_o)
		else $error("power down wake out of window");
	AST_SLEEP_EXIT: assert property (slp_ff &&
		|(irq_i & irq_mask_i) |=> core_clk_en_o)
		else $error("sleep not left on interrupt");
endmodule : pwr_seq_chk

bind pwr_mode_wake_seq pwr_seq_chk #(
	.NIRQ(NIRQ), .NPER(NPER), .IRC_START_CNT(IRC_START_CNT)
) i_pwr_seq_chk (
	.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
	.rtc_dpd_req_i(rtc_dpd_req_i), .rtc_alarm_i(rtc_alarm_i),
	.irq_i(irq_i), .irq_mask_i(irq_mask_i), .pclk_en_o(pclk_en_o),
	.core_clk_en_o(core_clk_en_o), .irc_out_en_o(irc_out_en_o),
	.irc_pwr_o(irc_pwr_o), .flash_pwr_o(flash_pwr_o),
	.chip_pwr_o(chip_pwr_o), .main_synth_en_o(main_synth_en_o),
	.main_synth_conn_o(main_synth_conn_o), .cpu_src_o(cpu_src_o),
	.usb_synth_pwr_o(usb_synth_pwr_o), .usb_clk_sel_o(usb_clk_sel_o),
	.cpu_div_o(cpu_div_o), .usb_div_o(usb_div_o), .wake_evt_o(wake_evt_o)
);

// ==== sim/tb_top.sv ====
// self-checking bench for the power mode and wake sequencer
`timescale 1ns/10ps
module tb_top;
	import pwr_seq_pkg::*;
	logic ref_clk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic rtc_dpd_req_i = 1'b0;
	logic rtc_alarm_i = 1'b0;
	wb_req_t req = '0;
	logic sleep_req, wb_ack_o, core_clk_en_o, irc_out_en_o, irc_pwr_o;
	logic flash_pwr_o, flash_ready_o, chip_pwr_o, main_synth_en_o;
	logic main_synth_conn_o, usb_synth_pwr_o, usb_clk_sel_o, wake_evt_o;
	logic [31:0] irq, irq_mask, wb_dat_o, q;
	logic [15:0] pclk_en_o;
	logic [1:0] cpu_src_o;
	logic [7:0] cpu_div_o;
	logic [3:0] usb_div_o;
	logic [2:0] clkout_sel_o;
	logic [31:0] mdl [0:4];
	int n_errors = 0, checks_done = 0, seed = 25732, n, m;
	always #5 ref_clk_i = ~ref_clk_i;
	core_irq_model i_core_irq_model (
		.ref_clk_i(ref_clk_i), .sleep_req_o(sleep_req),
		.irq_o(irq), .irq_mask_o(irq_mask)
	);
	// short start-up counts keep the run brief
	pwr_mode_wake_seq #(
		.IRC_START_CNT(20),
		.FLASH_WAKE_CNT(40)
	) i_pwr_mode_wake_seq (
		.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .clk_en_i(1'b1),
		.wb_req_i(req), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.sleep_req_i(sleep_req), .rtc_dpd_req_i(rtc_dpd_req_i),
		.rtc_alarm_i(rtc_alarm_i), .irq_i(irq), .irq_mask_i(irq_mask),
		.core_clk_en_o(core_clk_en_o), .pclk_en_o(pclk_en_o),
		.irc_out_en_o(irc_out_en_o), .irc_pwr_o(irc_pwr_o),
		.flash_pwr_o(flash_pwr_o), .flash_ready_o(flash_ready_o),
		.chip_pwr_o(chip_pwr_o), .main_synth_en_o(main_synth_en_o),
		.main_synth_conn_o(main_synth_conn_o),
		.usb_synth_pwr_o(usb_synth_pwr_o), .usb_clk_sel_o(usb_clk_sel_o),
		.cpu_src_o(cpu_src_o), .cpu_div_o(cpu_div_o),
		.usb_div_o(usb_div_o), .clkout_sel_o(clkout_sel_o),
		.wake_evt_o(wake_evt_o)
	);
	// ===================================
	// tasks
	task automatic complete_run();
		$display("checks %0d errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : complete_run
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_errors++;
			$display("Error t=%0t seen %h exp %h", $time, seen, exp);
		end
	endtask : chk
	function automatic logic [31:0] mrg(input logic [31:0] o,
		input logic [31:0] d, input logic [3:0] s);
		for (int b = 0; b < 4; b++)
			if (s[b])
				o[8*b+:8] = d[8*b+:8];
		return o;
	endfunction : mrg
	task automatic wb(input logic we, input logic [7:0] a,
		input logic [31:0] d, input logic [3:0] s, output logic [31:0] r);
		int k;
		k = 0;
		req <= '{1'b1, 1'b1, we, a, s, d};
		do begin
			@(posedge ref_clk_i);
			k++;
		end while (wb_ack_o !== 1'b1 && k < 20);
		r = wb_dat_o;
		req <= '0;
		@(posedge ref_clk_i);
		if (k >= 20) begin
			n_errors++;
			complete_run();
		end
	endtask : wb
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] s);
		wb(1'b1, a, d, s, q);
		if (a < OFS_STATUS)
			mdl[a[4:2]] = mrg(mdl[a[4:2]], d, s);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		wb(1'b0, a, 32'h0, 4'hF, q);
		chk(q, e);
	endtask : rd
	task automatic waitev(input bit fl, input int lim, output int k);
		k = 0;
		do begin
			@(posedge ref_clk_i);
			k++;
		end while ((fl ? flash_ready_o : wake_evt_o) !== 1'b1 && k < lim);
		if (k >= lim) begin
			n_errors++;
			complete_run();
		end
	endtask : waitev
	task automatic rtc(input bit al);
		@(posedge ref_clk_i);
		if (al)
			rtc_alarm_i <= 1'b1;
		else
			rtc_dpd_req_i <= 1'b1;
		@(posedge ref_clk_i);
		rtc_alarm_i <= 1'b0;
		rtc_dpd_req_i <= 1'b0;
		@(posedge ref_clk_i);
	endtask : rtc
	task automatic nap();
		i_core_irq_model.wfi();
		@(posedge ref_clk_i);
	endtask : nap
	task automatic wake_in(input int idx, input int lo, input int hi);
		fork
			i_core_irq_model.fire(idx, 3);
		join_none
		waitev(1'b0, hi + 5, n);
		chk(n >= lo && n <= hi, 1);
	endtask : wake_in
	// ===================================
	// sequence
	initial begin
		for (int i = 0; i < 5; i++)
			mdl[i] = '0;
		repeat (16) @(posedge ref_clk_i);
		sys_rst_i <= 1'b0;
		for (int i = 0; i < 5; i++)
			rd(8'(i * 4), mdl[i]);
		rd(8'h40, 32'h0);
		chk({usb_synth_pwr_o, usb_clk_sel_o}, 0);
		chk(cpu_src_o, SRC_IRC);
		$display("test reset done");
		for (int i = 0; i < 5; i++) begin
			wr(OFS_CLKOUT, i, 4'hF);
			chk(clkout_sel_o, i);
		end
		wr(OFS_PGATE, $random(seed) & 32'hFFFF, 4'($random(seed)));
		rd(OFS_PGATE, mdl[3]);
		repeat (8) begin
			@(posedge ref_clk_i);
			chk(pclk_en_o & ~mdl[3][15:0], 0);
		end
		// eight cycles span one prescaler lap: 8 >> code pulses each
		wr(OFS_PDIV, $random(seed), 4'hF);
		wr(OFS_PGATE, 32'hFFFF, 4'h3);
		for (int p = 0; p < 16; p++) begin
			n = 0;
			repeat (8) begin
				@(posedge ref_clk_i);
				n += pclk_en_o[p];
			end
			chk(n, 8 >> mdl[4][2*p+:2]);
		end
		wr(OFS_CTRL, 32'h10, 4'hF);
		chk(usb_clk_sel_o, 0);
		wr(OFS_CTRL, 32'h30, 4'hF);
		chk({usb_synth_pwr_o, usb_clk_sel_o}, 3);
		wr(OFS_CTRL, 32'h0, 4'hF);
		$display("test clocks done");
		nap();
		chk({core_clk_en_o, irc_out_en_o}, 1);
		rtc(1'b0);
		chk(chip_pwr_o, 1);
		i_core_irq_model.fire(4, 3);
		chk(core_clk_en_o, 1);
		$display("test sleep done");
		wr(OFS_CTRL, 32'h05, 4'hF);
		wr(OFS_CTRL, 32'h0D, 4'hF);
		wr(OFS_CLKDIV, 32'h0305, 4'hF);
		nap();
		mdl[0] = 32'h01;
		mdl[1] = 32'h0;
		chk({main_synth_en_o, main_synth_conn_o}, 0);
		chk({cpu_div_o, usb_div_o}, 0);
		chk(flash_pwr_o & irc_pwr_o & ~irc_out_en_o, 1);
		i_core_irq_model.fire(0, 3);
		chk(core_clk_en_o, 0);
		wake_in(5, 6, 12);
		rd(OFS_CTRL, mdl[0]);
		rd(OFS_CLKDIV, mdl[1]);
		wr(OFS_CLKDIV, 32'h0305, 4'hF);
		wr(OFS_CTRL, 32'h41, 4'hF);
		nap();
		mdl[1] = 32'h0;
		wake_in(6, 4098, 4106);
		$display("test deep sleep done");
		wr(OFS_CTRL, 32'h46, 4'hF);
		nap();
		mdl[0] = 32'h02;
		chk(irc_pwr_o | flash_pwr_o, 0);
		chk(cpu_src_o, SRC_IRC);
		wake_in(7, 24, 36);
		chk(flash_ready_o, 0);
		waitev(1'b1, 60, m);
		chk(n + m >= 60 && n + m <= 72, 1);
		rd(OFS_CTRL, mdl[0]);
		$display("test power down done");
		rtc(1'b0);
		chk(chip_pwr_o, 0);
		i_core_irq_model.fire(5, 3);
		chk(chip_pwr_o, 0);
		rtc(1'b1);
		waitev(1'b0, 60, n);
		chk(chip_pwr_o, 1);
		for (int i = 0; i < 5; i++) begin
			mdl[i] = '0;
			rd(8'(i * 4), mdl[i]);
		end
		$display("test deep power down done");
		complete_run();
	end
endmodule : tb_top
